// ---- core/sfcfe_defines.svh ----
`ifndef SFCFE_DEFINES_SVH
`define SFCFE_DEFINES_SVH

// ----------------------------------------------------------------
// command codes and framing
// ----------------------------------------------------------------
`define SFC_OP_LEGACY_READ  8'hE8
`define SFC_OP_PROTECT_SEQ  8'h3D
`define SFC_OPCODE_LAST     6'h07
`define SFC_ADDR_LAST       6'h17
`define SFC_DUMMY_LAST      6'h1F
`define SFC_TX_BITS_READ    7'h40
`define SFC_TX_BITS_CMD     7'h20

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define SFC_OFF_LAST_528    10'h20F
`define SFC_OFF_LAST_512    10'h1FF
`define SFC_PAGE_LAST       13'h1FFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SFC_MCLK_NS         10
`define SFC_SCK_HALF_NS     80
`define SFC_SCK_HALF_CYC    ((`SFC_SCK_HALF_NS + `SFC_MCLK_NS - 1) / `SFC_MCLK_NS)
`define SFC_POR_NS          200
`define SFC_POR_CYC         ((`SFC_POR_NS + `SFC_MCLK_NS - 1) / `SFC_MCLK_NS)

`endif

// ---- core/sfcfe_pkg.sv ----
package sfcfe_pkg;

    typedef logic [7:0]  sfcfe_byte_t;
    typedef logic [12:0] sfcfe_page_t;
    typedef logic [9:0]  sfcfe_off_t;

    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_OPCODE,
        DEV_ADDR,
        DEV_DUMMY,
        DEV_STREAM,
        DEV_IGNORE,
        DEV_WAIT_CS
    } sfcfe_dev_state_t;

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_SHIFT,
        HOST_READ,
        HOST_END
    } sfcfe_host_state_t;

endpackage

// ---- core/sfcfe_if.sv ----
`timescale 1ns/1ps

interface sfcfe_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic wp_n;
    logic rst_n;

    modport dev (
        input  cs_n,
        input  sck,
        input  si,
        input  wp_n,
        input  rst_n,
        output so,
        output so_oe
    );

    modport host (
        output cs_n,
        output sck,
        output si,
        output wp_n,
        output rst_n,
        input  so,
        input  so_oe
    );
endinterface

// ---- core/sfcfe_device.sv ----
`timescale 1ns/1ps
`include "sfcfe_defines.svh"


module sfcfe_device (
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    sfcfe_if.dev                  link,
    input  wire logic             i_page_512,
    output logic                  o_cmd_valid,
    output sfcfe_pkg::sfcfe_byte_t o_cmd_opcode,
    output logic                  o_cmd_blocked,
    output logic                  o_read_active
);
    import sfcfe_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic is_prog_erase(input sfcfe_byte_t op);
        case (op)
            8'h02, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
            8'h88, 8'h89, 8'h50, 8'h7C, 8'hC7, 8'h58, 8'h59: is_prog_erase = 1'b1;
            default: is_prog_erase = 1'b0;
        endcase
    endfunction

    // stand-in array content, derived from the address
    function automatic sfcfe_byte_t array_byte(input sfcfe_page_t pg, input sfcfe_off_t off);
        array_byte = pg[7:0] ^ off[7:0] ^ {6'h00, off[9:8]};
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] cs_s_q;
    logic [1:0] sck_s_q;
    logic [1:0] si_s_q;
    logic [1:0] wp_s_q;
    logic [1:0] rst_s_q;
    logic       cs_prev_q;
    logic       sck_prev_q;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_s_q     <= 2'h3;
            sck_s_q    <= 2'h0;
            si_s_q     <= 2'h0;
            wp_s_q     <= 2'h3;
            rst_s_q    <= 2'h0;
            cs_prev_q  <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            cs_s_q     <= {cs_s_q[0], link.cs_n};
            sck_s_q    <= {sck_s_q[0], link.sck};
            si_s_q     <= {si_s_q[0], link.si};
            wp_s_q     <= {wp_s_q[0], link.wp_n};
            rst_s_q    <= {rst_s_q[0], link.rst_n};
            cs_prev_q  <= cs_s_q[1];
            sck_prev_q <= sck_s_q[1];
        end
    end

    logic cs_n_sync;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic si_bit;

    assign cs_n_sync = cs_s_q[1];
    assign si_bit    = si_s_q[1];
    assign sck_rise  = sck_s_q[1] & ~sck_prev_q;
    assign sck_fall  = ~sck_s_q[1] & sck_prev_q;
    assign cs_fall   = cs_prev_q & ~cs_n_sync;

    // ----------------------------------------------------------------
    // internal power-on reset
    // ----------------------------------------------------------------
    logic [7:0] por_cnt_q;
    logic [7:0] por_cnt_d;
    logic       por_done;

    assign por_done = (por_cnt_q == 8'(`SFC_POR_CYC));

    always_comb begin
        por_cnt_d = por_done ? por_cnt_q : por_cnt_q + 8'h01;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            por_cnt_q <= 8'h00;
        end else begin
            por_cnt_q <= por_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // command and read engine
    // ----------------------------------------------------------------
    sfcfe_dev_state_t st_q, st_d;
    logic [5:0]       cnt_q, cnt_d;
    logic [22:0]      sr_q, sr_d;
    sfcfe_page_t      page_q, page_d;
    sfcfe_off_t       off_q, off_d;
    sfcfe_byte_t      dout_q, dout_d;
    logic [2:0]       obit_q, obit_d;
    logic             so_q, so_d;
    logic             oe_q, oe_d;
    logic             valid_q, valid_d;
    logic             blocked_q, blocked_d;
    sfcfe_byte_t      op_q, op_d;
    logic [23:0]      word;
    sfcfe_page_t      page_nx;
    sfcfe_off_t       off_nx;

    assign word = {sr_q, si_bit};

    always_comb begin
        page_nx = page_q;
        off_nx  = off_q + 10'h001;
        if (off_q == (i_page_512 ? `SFC_OFF_LAST_512 : `SFC_OFF_LAST_528)) begin
            off_nx = 10'h000;
            page_nx = (page_q == `SFC_PAGE_LAST) ? 13'h0000 : page_q + 13'h0001;
        end
    end

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        sr_d      = sr_q;
        page_d    = page_q;
        off_d     = off_q;
        dout_d    = dout_q;
        obit_d    = obit_q;
        so_d      = so_q;
        oe_d      = oe_q;
        op_d      = op_q;
        valid_d   = 1'b0;
        blocked_d = 1'b0;
        if (!por_done || !rst_s_q[1]) begin
            st_d  = DEV_IDLE;
            cnt_d = 6'h00;
            oe_d  = 1'b0;
        end else if (cs_n_sync) begin
            st_d  = DEV_IDLE;
            cnt_d = 6'h00;
            oe_d  = 1'b0;
        end else begin
            case (st_q)
                DEV_IDLE: begin
                    if (cs_fall) begin
                        st_d  = DEV_OPCODE;
                        cnt_d = 6'h00;
                    end
                end
                DEV_OPCODE: begin
                    if (sck_rise) begin
                        sr_d  = word[22:0];
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == `SFC_OPCODE_LAST) begin
                            op_d  = word[7:0];
                            cnt_d = 6'h00;
                            if (word[7:0] == `SFC_OP_LEGACY_READ) begin
                                st_d = DEV_ADDR;
                            end else if (is_prog_erase(word[7:0]) && !wp_s_q[1]) begin
                                st_d      = DEV_IGNORE;
                                blocked_d = 1'b1;
                            end else begin
                                st_d    = DEV_WAIT_CS;
                                valid_d = 1'b1;
                            end
                        end
                    end
                end
                DEV_ADDR: begin
                    if (sck_rise) begin
                        sr_d  = word[22:0];
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == `SFC_ADDR_LAST) begin
                            cnt_d = 6'h00;
                            st_d  = DEV_DUMMY;
                            if (i_page_512) begin
                                page_d = word[21:9];
                                off_d  = {1'b0, word[8:0]};
                            end else begin
                                page_d = word[22:10];
                                off_d  = word[9:0];
                            end
                        end
                    end
                end
                DEV_DUMMY: begin
                    if (sck_rise) begin
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == `SFC_DUMMY_LAST) begin
                            st_d    = DEV_STREAM;
                            dout_d  = array_byte(page_q, off_q);
                            obit_d  = 3'h0;
                            valid_d = 1'b1;
                        end
                    end
                end
                DEV_STREAM: begin
                    if (sck_fall) begin
                        so_d = dout_q[7];
                        oe_d = 1'b1;
                        if (obit_q == 3'h7) begin
                            page_d = page_nx;
                            off_d  = off_nx;
                            dout_d = array_byte(page_nx, off_nx);
                            obit_d = 3'h0;
                        end else begin
                            dout_d = {dout_q[6:0], 1'b0};
                            obit_d = obit_q + 3'h1;
                        end
                    end
                end
                DEV_IGNORE: begin
                    st_d = DEV_IGNORE;
                end
                DEV_WAIT_CS: begin
                    st_d = DEV_WAIT_CS;
                end
                default: begin
                    st_d = DEV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q      <= DEV_IDLE;
            cnt_q     <= 6'h00;
            sr_q      <= 23'h000000;
            page_q    <= 13'h0000;
            off_q     <= 10'h000;
            dout_q    <= 8'h00;
            obit_q    <= 3'h0;
            so_q      <= 1'b0;
            oe_q      <= 1'b0;
            op_q      <= 8'h00;
            valid_q   <= 1'b0;
            blocked_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            sr_q      <= sr_d;
            page_q    <= page_d;
            off_q     <= off_d;
            dout_q    <= dout_d;
            obit_q    <= obit_d;
            so_q      <= so_d;
            oe_q      <= oe_d;
            op_q      <= op_d;
            valid_q   <= valid_d;
            blocked_q <= blocked_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign link.so       = so_q;
    assign link.so_oe    = oe_q;
    assign o_cmd_valid   = valid_q;
    assign o_cmd_opcode  = op_q;
    assign o_cmd_blocked = blocked_q;
    assign o_read_active = oe_q;
endmodule

// ---- core/sfcfe_host.sv ----
`timescale 1ns/1ps
`include "sfcfe_defines.svh"

module sfcfe_host (
    input  wire logic              i_mclk,
    input  wire logic              i_reset_n,
    sfcfe_if.host                  link,
    input  wire logic              i_start,
    input  sfcfe_pkg::sfcfe_byte_t i_opcode,
    input  sfcfe_pkg::sfcfe_page_t i_page,
    input  sfcfe_pkg::sfcfe_off_t  i_offset,
    input  wire logic              i_page_512,
    input  wire logic              i_mode3,
    input  wire logic [15:0]       i_read_bytes,
    input  wire logic              i_wp_n,
    input  wire logic              i_hw_reset_n,
    output logic                   o_busy,
    output sfcfe_pkg::sfcfe_byte_t o_rdata,
    output logic                   o_rvalid
);
    import sfcfe_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [23:0] fmt_addr(input sfcfe_page_t pg, input sfcfe_off_t off,
                                             input logic p512);
        fmt_addr = p512 ? {2'b00, pg, off[8:0]} : {1'b0, pg, off};
    endfunction

    // ----------------------------------------------------------------
    // serial output synchroniser
    // ----------------------------------------------------------------
    logic [1:0] so_s_q;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            so_s_q <= 2'h0;
        end else begin
            so_s_q <= {so_s_q[0], link.so};
        end
    end

    // ----------------------------------------------------------------
    // frame engine, mode 0 or 3 clock from a divider
    // ----------------------------------------------------------------
    sfcfe_host_state_t st_q, st_d;
    logic [3:0]        div_q, div_d;
    logic              sck_q, sck_d;
    logic              cs_n_q, cs_n_d;
    logic              si_q, si_d;
    logic [63:0]       tx_q, tx_d;
    logic [6:0]        nbits_q, nbits_d;
    logic [6:0]        bit_q, bit_d;
    logic [15:0]       left_q, left_d;
    sfcfe_byte_t       rx_q, rx_d;
    logic [2:0]        rbit_q, rbit_d;
    sfcfe_byte_t       rdata_q, rdata_d;
    logic              rvalid_q, rvalid_d;
    logic              busy_q, busy_d;
    logic              wp_q, rst_q;
    logic              tick;
    logic              is_read;

    assign tick    = (div_q == 4'(`SFC_SCK_HALF_CYC - 1));
    assign is_read = (i_opcode == `SFC_OP_LEGACY_READ);

    always_comb begin
        st_d     = st_q;
        div_d    = (st_q == HOST_IDLE || tick) ? 4'h0 : div_q + 4'h1;
        sck_d    = sck_q;
        cs_n_d   = cs_n_q;
        si_d     = si_q;
        tx_d     = tx_q;
        nbits_d  = nbits_q;
        bit_d    = bit_q;
        left_d   = left_q;
        rx_d     = rx_q;
        rbit_d   = rbit_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        case (st_q)
            HOST_IDLE: begin
                sck_d = i_mode3;
                if (i_start) begin
                    st_d    = HOST_SHIFT;
                    cs_n_d  = 1'b0;
                    tx_d    = {i_opcode, fmt_addr(i_page, i_offset, i_page_512), 32'h00000000};
                    si_d    = i_opcode[7];
                    nbits_d = is_read ? `SFC_TX_BITS_READ : `SFC_TX_BITS_CMD;
                    bit_d   = 7'h00;
                    left_d  = is_read ? i_read_bytes : 16'h0000;
                    rbit_d  = 3'h0;
                end
            end
            HOST_SHIFT: begin
                if (tick) begin
                    sck_d = ~sck_q;
                    if (!sck_q) begin
                        bit_d = bit_q + 7'h01;
                    end else if (bit_q == nbits_q) begin
                        st_d = (left_q == 16'h0000) ? HOST_END : HOST_READ;
                    end else if (bit_q != 7'h00) begin
                        // mode 3 opening fall carries no bit
                        tx_d = {tx_q[62:0], 1'b0};
                        si_d = tx_q[62];
                    end
                end
            end
            HOST_READ: begin
                if (tick) begin
                    sck_d = ~sck_q;
                    if (!sck_q) begin
                        rx_d   = {rx_q[6:0], so_s_q[1]};
                        rbit_d = rbit_q + 3'h1;
                        if (rbit_q == 3'h7) begin
                            rdata_d  = {rx_q[6:0], so_s_q[1]};
                            rvalid_d = 1'b1;
                            left_d   = left_q - 16'h0001;
                        end
                    end else if (left_q == 16'h0000) begin
                        st_d = HOST_END;
                    end
                end
            end
            HOST_END: begin
                cs_n_d = 1'b1;
                st_d   = HOST_IDLE;
            end
            default: begin
                st_d = HOST_IDLE;
            end
        endcase
        busy_d = (st_d != HOST_IDLE);
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q     <= HOST_IDLE;
            div_q    <= 4'h0;
            sck_q    <= 1'b0;
            cs_n_q   <= 1'b1;
            si_q     <= 1'b0;
            tx_q     <= 64'h0000000000000000;
            nbits_q  <= 7'h00;
            bit_q    <= 7'h00;
            left_q   <= 16'h0000;
            rx_q     <= 8'h00;
            rbit_q   <= 3'h0;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            busy_q   <= 1'b0;
            wp_q     <= 1'b1;
            rst_q    <= 1'b1;
        end else begin
            st_q     <= st_d;
            div_q    <= div_d;
            sck_q    <= sck_d;
            cs_n_q   <= cs_n_d;
            si_q     <= si_d;
            tx_q     <= tx_d;
            nbits_q  <= nbits_d;
            bit_q    <= bit_d;
            left_q   <= left_d;
            rx_q     <= rx_d;
            rbit_q   <= rbit_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            busy_q   <= busy_d;
            wp_q     <= i_wp_n;
            rst_q    <= i_hw_reset_n;
        end
    end

    assign link.cs_n  = cs_n_q;
    assign link.sck   = sck_q;
    assign link.si    = si_q;
    assign link.wp_n  = wp_q;
    assign link.rst_n = rst_q;
    assign o_busy     = busy_q;
    assign o_rdata    = rdata_q;
    assign o_rvalid   = rvalid_q;
endmodule

// ---- tb/sfcfe_link_properties.sv ----
`timescale 1ns/1ps

module sfcfe_link_properties (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_so,
    input wire logic i_so_oe,
    input wire logic i_wp_n,
    input wire logic i_rst_n
);
    // ------------------------------------------------------------
    // serial clock rises within the current frame
    // ------------------------------------------------------------
    logic [15:0] rise_cnt_q;
    logic [15:0] rise_cnt_d;
    logic        sck_q;

    always_comb begin
        rise_cnt_d = rise_cnt_q;
        if (i_cs_n) begin
            rise_cnt_d = 16'h0000;
        end else if (i_sck && !sck_q && rise_cnt_q != 16'hFFFF) begin
            rise_cnt_d = rise_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rise_cnt_q <= 16'h0000;
            sck_q      <= 1'b0;
        end else begin
            rise_cnt_q <= rise_cnt_d;
            sck_q      <= i_sck;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_oe_select_only: assert property (i_cs_n [*6] |-> !i_so_oe)
        else $error("output driven while deselected");
    a_oe_after_dummies: assert property (
        i_so_oe && !i_cs_n |-> rise_cnt_q >= 16'h0040)
        else $error("output driven before opcode, address and dummies");
    a_read_end_float: assert property ($rose(i_cs_n) |-> ##[1:5] !i_so_oe)
        else $error("output not released after deselect");
    a_reset_pin_float: assert property ((!i_rst_n) [*5] |-> !i_so_oe)
        else $error("output driven while reset pin low");
    a_so_launch_fall: assert property (
        i_so_oe && $past(i_so_oe) && $changed(i_so) |-> !i_sck)
        else $error("output data changed while serial clock high");
    a_oe_rise_clk_low: assert property ($rose(i_so_oe) |-> !i_sck && !i_cs_n)
        else $error("stream started outside a falling serial clock phase");
    a_si_stable_rise: assert property ($rose(i_sck) |-> $stable(i_si))
        else $error("input data moved at serial clock rise");
    a_sck_rest_select: assert property ($fell(i_cs_n) |-> $stable(i_sck))
        else $error("serial clock moved at select fall");
    a_cs_gap_min: assert property ($rose(i_cs_n) |-> i_cs_n [*3])
        else $error("deselect gap too short");

    cover property ($rose(i_so_oe));
    cover property (!i_rst_n && !i_cs_n);
    cover property ($fell(i_cs_n) && !i_wp_n);
    cover property ($fell(i_cs_n) && i_sck);
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps

module tb;
    import sfcfe_pkg::*;

    logic        mclk = 1'b0;
    logic        reset_n, start, page_512, mode3, wp_n, hw_reset_n;
    logic        busy, rvalid, cmd_valid, cmd_blocked, read_active;
    sfcfe_byte_t opcode, rdata, cmd_opcode;
    sfcfe_page_t page;
    sfcfe_off_t  offset;
    logic [15:0] read_bytes;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          n_valid = 0;
    int          n_blocked = 0;
    sfcfe_byte_t rx_q[$];

    always #5 mclk = ~mclk;

    sfcfe_if link_if();

    sfcfe_device i_sfcfe_device (.i_mclk(mclk), .i_reset_n(reset_n), .link(link_if.dev),
        .i_page_512(page_512), .o_cmd_valid(cmd_valid), .o_cmd_opcode(cmd_opcode),
        .o_cmd_blocked(cmd_blocked), .o_read_active(read_active));

    sfcfe_host i_sfcfe_host (.i_mclk(mclk), .i_reset_n(reset_n), .link(link_if.host),
        .i_start(start), .i_opcode(opcode), .i_page(page), .i_offset(offset),
        .i_page_512(page_512), .i_mode3(mode3), .i_read_bytes(read_bytes), .i_wp_n(wp_n),
        .i_hw_reset_n(hw_reset_n), .o_busy(busy), .o_rdata(rdata), .o_rvalid(rvalid));

    sfcfe_link_properties i_sfcfe_link_properties (.i_mclk(mclk), .i_reset_n(reset_n),
        .i_cs_n(link_if.cs_n), .i_sck(link_if.sck), .i_si(link_if.si), .i_so(link_if.so),
        .i_so_oe(link_if.so_oe), .i_wp_n(link_if.wp_n), .i_rst_n(link_if.rst_n));

    // ------------------------------------------------------------
    // monitors and common tasks
    // ------------------------------------------------------------
    always @(negedge mclk) begin
        cycles++;
        if (rvalid === 1'b1) rx_q.push_back(rdata);
        if (cmd_valid === 1'b1) n_valid++;
        if (cmd_blocked === 1'b1) n_blocked++;
        if (cycles == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic launch(input sfcfe_byte_t op, input sfcfe_page_t pg,
                          input sfcfe_off_t off, input logic [15:0] n);
        @(negedge mclk);
        opcode = op;
        page = pg;
        offset = off;
        read_bytes = n;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
    endtask

    task automatic finish_frame();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 20000) begin
            @(negedge mclk);
            k++;
        end
        // device pulses lag the pins by a few cycles
        repeat (8) @(negedge mclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic protect_gating();
        sfcfe_byte_t codes[3] = '{8'h02, 8'h81, 8'hC7};
        int nb;
        int nv;
        wp_n = 1'b0;
        foreach (codes[i]) begin
            nb = n_blocked;
            nv = n_valid;
            launch(codes[i], 13'h0000, 10'h000, 16'h0000);
            finish_frame();
            check("blocked pulse", 16'(n_blocked - nb), 16'h0001);
            check("no accept", 16'(n_valid - nv), 16'h0000);
        end
        nv = n_valid;
        launch(8'h3D, 13'h0000, 10'h000, 16'h0000);
        finish_frame();
        check("protect cmd taken", 16'(n_valid - nv), 16'h0001);
        check("protect opcode", 16'(cmd_opcode), 16'h003D);
        wp_n = 1'b1;
        nb = n_blocked;
        launch(8'h02, 13'h0000, 10'h000, 16'h0000);
        finish_frame();
        check("unprotected not blocked", 16'(n_blocked - nb), 16'h0000);
    endtask

    task automatic reset_pin_abort();
        int k;
        page_512 = 1'b0;
        rx_q.delete();
        launch(8'hE8, 13'h0010, 10'h000, 16'h0004);
        k = 0;
        while (rx_q.size() == 0 && k < 5000) begin
            @(negedge mclk);
            k++;
        end
        check("stream before reset", 16'(read_active), 16'h0001);
        hw_reset_n = 1'b0;
        repeat (12) @(negedge mclk);
        check("abort on reset pin", 16'(read_active), 16'h0000);
        repeat (200) @(negedge mclk);
        check("held in reset", 16'(read_active), 16'h0000);
        hw_reset_n = 1'b1;
        finish_frame();
    endtask

    task automatic read_check(input logic p512, input logic m3, input sfcfe_page_t pg,
                              input sfcfe_off_t off, input int n);
        sfcfe_page_t ep;
        sfcfe_off_t  eo;
        @(negedge mclk);
        page_512 = p512;
        mode3 = m3;
        rx_q.delete();
        ep = pg;
        eo = off;
        launch(8'hE8, pg, off, 16'(n));
        finish_frame();
        check("byte count", 16'(rx_q.size()), 16'(n));
        for (int k = 0; k < n && k < rx_q.size(); k++) begin
            check("stream byte", {8'h00, rx_q[k]}, {8'h00, ep[7:0] ^ eo[7:0] ^ {6'h00, eo[9:8]}});
            if (eo == (p512 ? 10'h1FF : 10'h20F)) begin
                eo = 10'h000;
                ep = ep + 13'h0001;
            end else begin
                eo = eo + 10'h001;
            end
        end
    endtask

    initial begin
        reset_n = 1'b0;
        start = 1'b0;
        page_512 = 1'b0;
        mode3 = 1'b0;
        wp_n = 1'b1;
        hw_reset_n = 1'b1;
        opcode = 8'h00;
        page = 13'h0000;
        offset = 10'h000;
        read_bytes = 16'h0000;
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        // internal power-on hold plus sync
        repeat (30) @(negedge mclk);
        protect_gating();
        reset_pin_abort();
        read_check(1'b0, 1'b0, 13'h0005, 10'h20E, 3);
        read_check(1'b1, 1'b0, 13'h1FFF, 10'h1FF, 2);
        read_check(1'b0, 1'b0, 13'h1FFF, 10'h20F, 2);
        read_check(1'b1, 1'b1, 13'h0ABC, 10'h1FE, 3);
        tally_and_finish();
    end
endmodule
